/* File: verilog/ocpw_pkg.sv */
package ocpw_pkg;

  // channel count and widths
  localparam int NCH = 4;
  localparam int CW = 16;
  localparam int AW = 12;

  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [AW-1:0] OFF_MOD = 12'h004;
  localparam logic [AW-1:0] OFF_STAT = 12'h008;
  localparam logic [AW-1:0] OFF_CNT = 12'h00c;
  localparam logic [AW-1:0] OFF_CH_CTL = 12'h010;
  localparam logic [AW-1:0] OFF_CH_VAL = 12'h014;
  localparam logic [AW-1:0] CH_STRIDE = 12'h008;

  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int STAT_OVF_BIT = 8;
  localparam int CH_CTL_W = 6;

  // decoded register ids
  localparam logic [3:0] RID_CTRL = 4'h0;
  localparam logic [3:0] RID_MOD = 4'h1;
  localparam logic [3:0] RID_STAT = 4'h2;
  localparam logic [3:0] RID_CNT = 4'h3;
  localparam logic [3:0] RID_CH_CTL = 4'h4;
  localparam logic [3:0] RID_CH_VAL = 4'h8;
  localparam logic [3:0] RID_NONE = 4'hf;

  // values after reset
  localparam logic [CW-1:0] MOD_RST = 16'hffff;
  localparam logic [CW-1:0] VAL_RST = 16'h0000;
  localparam logic RUN_RST = 1'b0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-channel control word, lsb first: els_low, els_high, tog_ovf, force_max, pwm, buffered
  typedef struct packed {
    logic buffered;
    logic pwm;
    logic force_max;
    logic tog_ovf;
    logic edge_level_select_high;
    logic edge_level_select_low;
  } ocpw_chctl_t;

  localparam ocpw_chctl_t CHCTL_RST = 6'h00;

  // edge/level select encodings
  localparam logic [1:0] ELS_PORT = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

  // timebase shared by all channels
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic step;
    logic ovf;
  } ocpw_time_t;

  typedef struct packed {
    logic pin;
  } ocpw_chst_t;

  typedef struct packed {
    logic run;
    logic cnt_clr;
    logic [CW-1:0] modulo;
    logic [NCH-1:0] ch_flag;
    logic ovf_flag;
    ocpw_chctl_t [NCH-1:0] ctl;
    logic [NCH-1:0][CW-1:0] val;
    logic [NCH/2-1:0] sel_b;
    logic [NCH-1:0] pend;
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ocpw_top_t;

endpackage : ocpw_pkg

/* File: verilog/ocpw_counter.sv */
module ocpw_counter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic clr,
  input wire logic [ocpw_pkg::CW-1:0] modulo,
  // timebase
  output ocpw_pkg::ocpw_time_t tb
);

  ocpw_pkg::ocpw_time_t s_reg;
  ocpw_pkg::ocpw_time_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.step = 1'b0;
    s_next.ovf = 1'b0;
    if (clr) begin
      s_next.cnt = '0;
    end else if (run && tick) begin
      s_next.step = 1'b1;
      if (s_reg.cnt == modulo) begin
        // wrap on the count after the modulo value
        s_next.cnt = '0;
        s_next.ovf = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign tb = s_reg;

endmodule : ocpw_counter

/* File: verilog/ocpw_chan.sv */
module ocpw_chan (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // configuration
  input ocpw_pkg::ocpw_chctl_t ctl,
  input wire logic owned,
  input wire logic [ocpw_pkg::CW-1:0] cmp_val,
  // timebase
  input ocpw_pkg::ocpw_time_t tb,
  // pin and event
  output logic pin_out,
  output logic pin_oe,
  output logic match
);

  ocpw_pkg::ocpw_chst_t s_reg;
  ocpw_pkg::ocpw_chst_t s_next;
  logic [1:0] els;
  logic active;
  logic start_lvl;

  assign els = {ctl.edge_level_select_high, ctl.edge_level_select_low};
  assign active = owned && (els != ocpw_pkg::ELS_PORT);
  // compare is taken when the counter lands on the value, so a width of n is n counts
  assign match = active && tb.step && (tb.cnt == cmp_val);
  // clear-on-match pulses start high, set-on-match pulses start low
  assign start_lvl = (els == ocpw_pkg::ELS_CLEAR);

  always_comb begin
    s_next = s_reg;
    if (active) begin
      if (ctl.pwm && els != ocpw_pkg::ELS_TOGGLE) begin
        if (ctl.force_max) begin
          s_next.pin = start_lvl;
        end else begin
          if (tb.ovf) begin
            s_next.pin = start_lvl;
          end
          // a match on the overflow count wins, giving 0% width
          if (match) begin
            s_next.pin = ~start_lvl;
          end
        end
      end else begin
        if (tb.ovf && ctl.tog_ovf) begin
          s_next.pin = ~s_next.pin;
        end
        if (match) begin
          case (els)
            ocpw_pkg::ELS_TOGGLE: s_next.pin = ~s_next.pin;
            ocpw_pkg::ELS_CLEAR: s_next.pin = 1'b0;
            ocpw_pkg::ELS_SET: s_next.pin = 1'b1;
            default: s_next.pin = s_next.pin;
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign pin_out = s_reg.pin;
  assign pin_oe = active;

endmodule : ocpw_chan

/* File: verilog/ocpw_top.sv */
module ocpw_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // counter clock enable from the prescaler
  input wire logic count_tick,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ocpw_pkg::AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ocpw_pkg::AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // channel pins
  output logic [ocpw_pkg::NCH-1:0] chan_out,
  output logic [ocpw_pkg::NCH-1:0] chan_oe
);

  ocpw_pkg::ocpw_top_t s_reg;
  ocpw_pkg::ocpw_top_t s_next;
  ocpw_pkg::ocpw_time_t tb;
  logic [ocpw_pkg::NCH-1:0] match;
  logic [ocpw_pkg::NCH-1:0] owned;
  logic [ocpw_pkg::NCH-1:0][ocpw_pkg::CW-1:0] cmp_val;

  // decode used by both the read and the write path
  function automatic logic [3:0] reg_id(input logic [ocpw_pkg::AW-1:0] a);
    logic [3:0] id;
    id = ocpw_pkg::RID_NONE;
    if (a == ocpw_pkg::OFF_CTRL) begin
      id = ocpw_pkg::RID_CTRL;
    end else if (a == ocpw_pkg::OFF_MOD) begin
      id = ocpw_pkg::RID_MOD;
    end else if (a == ocpw_pkg::OFF_STAT) begin
      id = ocpw_pkg::RID_STAT;
    end else if (a == ocpw_pkg::OFF_CNT) begin
      id = ocpw_pkg::RID_CNT;
    end
    for (int i = 0; i < ocpw_pkg::NCH; i++) begin
      if (a == ocpw_pkg::OFF_CH_CTL + ocpw_pkg::AW'(i) * ocpw_pkg::CH_STRIDE) begin
        id = ocpw_pkg::RID_CH_CTL + 4'(i);
      end
      if (a == ocpw_pkg::OFF_CH_VAL + ocpw_pkg::AW'(i) * ocpw_pkg::CH_STRIDE) begin
        id = ocpw_pkg::RID_CH_VAL + 4'(i);
      end
    end
    return id;
  endfunction : reg_id

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // true when register k is the one its pair compares against; both
  // registers of an unbuffered pair count as active, so writes land at once
  function automatic logic reg_active(input ocpw_pkg::ocpw_top_t s, input int k);
    logic a;
    a = 1'b1;
    if (s.ctl[k & ~1].buffered) begin
      a = (s.sel_b[k/2] == k[0]);
    end
    return a;
  endfunction : reg_active

  // shared timebase
  ocpw_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(s_reg.run),
    .tick(count_tick),
    .clr(s_reg.cnt_clr),
    .modulo(s_reg.modulo),
    .tb(tb)
  );

  // channels; an even channel with buffered set owns its odd partner
  for (genvar g = 0; g < ocpw_pkg::NCH; g++) begin : g_ch
    if (g % 2 == 0) begin : g_even
      assign owned[g] = 1'b1;
      assign cmp_val[g] = reg_active(s_reg, g) ?
                          s_reg.val[g] : s_reg.val[g+1];
    end else begin : g_odd
      assign owned[g] = !s_reg.ctl[g-1].buffered;
      assign cmp_val[g] = s_reg.val[g];
    end
    ocpw_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .ctl(s_reg.ctl[g]),
      .owned(owned[g]),
      .cmp_val(cmp_val[g]),
      .tb(tb),
      .pin_out(chan_out[g]),
      .pin_oe(chan_oe[g]),
      .match(match[g])
    );
  end

  always_comb begin
    logic [3:0] wid;
    logic [3:0] rid;
    logic [31:0] cur;
    logic [31:0] mw;
    int k;
    s_next = s_reg;
    wid = reg_id(s_reg.aw_addr);
    rid = reg_id(araddr);
    cur = '0;
    mw = '0;
    k = 0;
    s_next.cnt_clr = 1'b0;

    // channel handshakes
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end

    // pair hand-over happens only at overflow, so a write to the inactive register never cuts a pulse short
    // a write to the active register took effect already and leaves nothing pending
    if (tb.ovf) begin
      for (int p = 0; p < ocpw_pkg::NCH / 2; p++) begin
        if (s_reg.ctl[2*p].buffered) begin
          if (!s_reg.sel_b[p] && s_reg.pend[2*p+1]) begin
            s_next.sel_b[p] = 1'b1;
            s_next.pend[2*p+1] = 1'b0;
          end else if (s_reg.sel_b[p] && s_reg.pend[2*p]) begin
            s_next.sel_b[p] = 1'b0;
            s_next.pend[2*p] = 1'b0;
          end
        end
      end
    end

    // a pair that leaves buffered mode forgets its select and pending hand-over,
    // so buffering switched on again always starts from the even register
    for (int p = 0; p < ocpw_pkg::NCH / 2; p++) begin
      if (!s_reg.ctl[2*p].buffered) begin
        s_next.sel_b[p] = 1'b0;
        s_next.pend[2*p] = 1'b0;
        s_next.pend[2*p+1] = 1'b0;
      end
    end

    // register write once address and data are both held
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (wid == ocpw_pkg::RID_NONE) ? ocpw_pkg::RESP_SLVERR : ocpw_pkg::RESP_OKAY;
      if (wid == ocpw_pkg::RID_CTRL) begin
        cur = 32'(s_reg.run);
        mw = lane_merge(cur, s_reg.wdata, s_reg.wstrb);
        s_next.run = mw[ocpw_pkg::CTRL_RUN_BIT];
        s_next.cnt_clr = mw[ocpw_pkg::CTRL_CLR_BIT];
      end else if (wid == ocpw_pkg::RID_MOD) begin
        mw = lane_merge(32'(s_reg.modulo), s_reg.wdata, s_reg.wstrb);
        s_next.modulo = mw[ocpw_pkg::CW-1:0];
      end else if (wid == ocpw_pkg::RID_STAT) begin
        mw = lane_merge('0, s_reg.wdata, s_reg.wstrb);
        s_next.ch_flag = s_reg.ch_flag & ~mw[ocpw_pkg::NCH-1:0];
        s_next.ovf_flag = s_reg.ovf_flag & ~mw[ocpw_pkg::STAT_OVF_BIT];
      end else if (wid >= ocpw_pkg::RID_CH_CTL && wid < ocpw_pkg::RID_CH_VAL) begin
        k = int'(wid - ocpw_pkg::RID_CH_CTL);
        mw = lane_merge(32'(s_reg.ctl[k]), s_reg.wdata, s_reg.wstrb);
        s_next.ctl[k] = mw[ocpw_pkg::CH_CTL_W-1:0];
      end else if (wid >= ocpw_pkg::RID_CH_VAL && wid < ocpw_pkg::RID_NONE) begin
        k = int'(wid - ocpw_pkg::RID_CH_VAL);
        mw = lane_merge(32'(s_reg.val[k]), s_reg.wdata, s_reg.wstrb);
        // active register takes effect at once; that is the unbuffered behaviour
        s_next.val[k] = mw[ocpw_pkg::CW-1:0];
        if (!reg_active(s_reg, k)) begin
          s_next.pend[k] = 1'b1;
        end
      end
    end

    // hardware sets after software clears, so a same-cycle event survives
    for (int c = 0; c < ocpw_pkg::NCH; c++) begin
      if (match[c]) begin
        s_next.ch_flag[c] = 1'b1;
      end
    end
    if (tb.ovf) begin
      s_next.ovf_flag = 1'b1;
    end

    // register read
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = ocpw_pkg::RESP_OKAY;
      s_next.rdata = '0;
      if (rid == ocpw_pkg::RID_CTRL) begin
        s_next.rdata[ocpw_pkg::CTRL_RUN_BIT] = s_reg.run;
      end else if (rid == ocpw_pkg::RID_MOD) begin
        s_next.rdata = 32'(s_reg.modulo);
      end else if (rid == ocpw_pkg::RID_STAT) begin
        s_next.rdata[ocpw_pkg::NCH-1:0] = s_reg.ch_flag;
        s_next.rdata[ocpw_pkg::STAT_OVF_BIT] = s_reg.ovf_flag;
        s_next.rdata[ocpw_pkg::STAT_OVF_BIT+1 +: ocpw_pkg::NCH/2] = s_reg.sel_b;
      end else if (rid == ocpw_pkg::RID_CNT) begin
        s_next.rdata = 32'(tb.cnt);
      end else if (rid >= ocpw_pkg::RID_CH_CTL && rid < ocpw_pkg::RID_CH_VAL) begin
        s_next.rdata = 32'(s_reg.ctl[int'(rid - ocpw_pkg::RID_CH_CTL)]);
      end else if (rid >= ocpw_pkg::RID_CH_VAL && rid < ocpw_pkg::RID_NONE) begin
        s_next.rdata = 32'(s_reg.val[int'(rid - ocpw_pkg::RID_CH_VAL)]);
      end else begin
        s_next.rresp = ocpw_pkg::RESP_SLVERR;
      end
    end
  end

  // bus state freezes with the rest while the clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // fields that come up non-zero are set over the clear
      s_reg <= '0;
      s_reg.run <= ocpw_pkg::RUN_RST;
      s_reg.modulo <= ocpw_pkg::MOD_RST;
      s_reg.ctl <= {ocpw_pkg::NCH{ocpw_pkg::CHCTL_RST}};
      s_reg.val <= {ocpw_pkg::NCH{ocpw_pkg::VAL_RST}};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // one write and one read in flight at a time
  // readys drop while the clock enable is low: the frozen state could not
  // capture a beat, and a master would otherwise count it as taken
  // limitation: a response taken while frozen is shown once more afterwards
  assign awready = ce && !s_reg.aw_got && !s_reg.bvalid;
  assign wready = ce && !s_reg.w_got && !s_reg.bvalid;
  assign arready = ce && !s_reg.rvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;

endmodule : ocpw_top

/* File: tb/ocpw_top_assertions.sv */
module ocpw_top_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic count_tick,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ocpw_pkg::AW-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // pins
  input wire logic [ocpw_pkg::NCH-1:0] chan_out,
  input wire logic [ocpw_pkg::NCH-1:0] chan_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed before bready");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read data dropped or changed before rready");
  write_answer_a: assert property ((ce && awvalid && awready && wvalid && wready) ##1 ce
    |=> bvalid)
    else $error("no write response two cycles after address and data");
  read_answer_a: assert property (ce && arvalid && arready |=> rvalid)
    else $error("no read data one cycle after read address");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready while response pending");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read address ready while read data pending");
  read_unmapped_a: assert property (ce && arvalid && arready &&
    (araddr > 12'h02c || araddr[1:0] != 2'h0) |=> rresp == ocpw_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  // enable comes only from control registers, so it moves only with a write
  oe_by_write_a: assert property ($past(aresetn) && $changed(chan_oe) |-> bvalid)
    else $error("pin enable changed without a register write");
  // pins move on counter events; a write may also move them (force, mode change)
  pin_by_tick_a: assert property ($past(aresetn) && $changed(chan_out) |->
    $past(count_tick) || $past(count_tick, 2) || $past(count_tick, 3) || bvalid || $past(bvalid))
    else $error("pin changed without a counter tick or a write");

  cover property (bvalid && bready);
  cover property (rvalid && rresp == ocpw_pkg::RESP_SLVERR);
  cover property ($rose(chan_out[0]));
endmodule : ocpw_top_assertions

bind ocpw_top ocpw_top_assertions u_ocpw_top_assertions (
  .aclk, .aresetn, .ce, .count_tick, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .chan_out, .chan_oe
);

/* File: tb/ocpw_pin_load.sv */
module ocpw_pin_load (
  // pins from the block
  input wire logic [ocpw_pkg::NCH-1:0] chan_out,
  input wire logic [ocpw_pkg::NCH-1:0] chan_oe,
  // level seen by the load
  output logic [ocpw_pkg::NCH-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up: a released pin reads high, never the last driven value
  assign pin_lvl = (chan_out & chan_oe) | ~chan_oe;
endmodule : ocpw_pin_load

/* File: tb/ocpw_top_test.sv */
module ocpw_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic count_tick = 1'b0;
  logic ce = 1'b1;
  logic tick_slow = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v, w;
  logic [3:0] chan_out, chan_oe, pin_lvl;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0, n, hi, per;
  logic [5:0] oc_ctl [3] = '{6'h06, 6'h07, 6'h01};
  logic [31:0] oc_hi [3] = '{32'h0a, 32'h5a, 32'h64};
  logic [31:0] oc_per [3] = '{32'h64, 32'h64, 32'hc8};

  always #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // slow mode halves the counter clock to show resolution follows the tick
  always @(posedge aclk) count_tick <= tick_slow ? ~count_tick : 1'b1;

  ocpw_top u_ocpw_top (
    .aclk, .aresetn, .ce, .count_tick, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .chan_out, .chan_oe
  );
  ocpw_pin_load u_ocpw_pin_load (.chan_out, .chan_oe, .pin_lvl);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  function automatic logic [11:0] adr(input logic [11:0] base, input int ch);
    return base + ocpw_pkg::CH_STRIDE * 12'(ch);
  endfunction : adr

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = ocpw_pkg::RESP_OKAY);
    logic ga, gw, ok;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      ga = awvalid && awready;
      gw = wvalid && wready;
      ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    input logic [1:0] er = ocpw_pkg::RESP_OKAY);
    logic g, ok;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge aclk);
      g = arvalid && arready;
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (g) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : rd

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  task automatic wait_chg(input int ch, input int lim);
    logic s;
    s = pin_lvl[ch];
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (pin_lvl[ch] === s && n < lim);
  endtask : wait_chg

  task automatic meas(input int ch);
    wait_chg(ch, 3000);
    if (pin_lvl[ch] !== 1'b1) wait_chg(ch, 3000);
    t0 = cyc;
    wait_chg(ch, 3000);
    hi = cyc - t0;
    wait_chg(ch, 3000);
    per = cyc - t0;
  endtask : meas

  task automatic cfg(input int ch, input logic [5:0] c, input logic [15:0] val,
                     input logic [15:0] md);
    wr(ocpw_pkg::OFF_MOD, {16'h0, md});
    wr(adr(ocpw_pkg::OFF_CH_VAL, ch), {16'h0, val});
    wr(adr(ocpw_pkg::OFF_CH_CTL, ch), {26'h0, c});
    wr(ocpw_pkg::OFF_CTRL, 32'h1);
  endtask : cfg

  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    give_verdict;
  end

  initial begin
    rst;
    rd(ocpw_pkg::OFF_MOD, v);
    chk(v, 32'h0000ffff);
    chk({28'h0, chan_oe}, 32'h0);
    wr(adr(ocpw_pkg::OFF_CH_VAL, 1), 32'hffff1234);
    rd(adr(ocpw_pkg::OFF_CH_VAL, 1), v);
    chk(v, 32'h00001234);
    rd(12'h030, v, ocpw_pkg::RESP_SLVERR);
    chk(v, 32'h0);
    wr(12'h031, 32'h1, ocpw_pkg::RESP_SLVERR);
    for (int d = 0; d < 2; d++) begin
      rst;
      tick_slow <= d[0];
      cfg(0, 6'h12, 16'h0080, 16'h00ff);
      meas(0);
      chk(32'(hi), 32'h80 << d);
      chk(32'(per), 32'h100 << d);
    end
    wr(ocpw_pkg::OFF_STAT, 32'h10f);
    wait_chg(0, 3000);
    rd(ocpw_pkg::OFF_STAT, v);
    chk(v & 32'h1, 32'h1);
    tick_slow <= 1'b0;
    rst;
    cfg(0, 6'h13, 16'h0040, 16'h00ff);
    meas(0);
    chk(32'(hi), 32'hc0);
    for (int f = 0; f < 2; f++) begin
      rst;
      cfg(0, f ? 6'h12 : 6'h1a, f ? 16'h0 : 16'h40, 16'h00ff);
      repeat (300) @(posedge aclk);
      wait_chg(0, 2000);
      chk(32'(n), 32'h7d0);
      chk({31'h0, pin_lvl[0]}, f ? 32'h0 : 32'h1);
    end
    for (int m = 0; m < 3; m++) begin
      rst;
      cfg(0, oc_ctl[m], 16'h000a, 16'h0063);
      meas(0);
      chk(32'(hi), oc_hi[m]);
      chk(32'(per), oc_per[m]);
    end
    wr(ocpw_pkg::OFF_CTRL, 32'h0);
    rd(ocpw_pkg::OFF_STAT, v);
    chk(v & 32'h1, 32'h1);
    wr(ocpw_pkg::OFF_STAT, 32'h1);
    rd(ocpw_pkg::OFF_STAT, v);
    chk(v & 32'h1, 32'h0);
    rst;
    cfg(0, 6'h01, 16'h000a, 16'h00c7);
    wait_chg(0, 3000);
    t0 = cyc;
    wr(ocpw_pkg::OFF_CH_VAL, 32'h96);
    wait_chg(0, 3000);
    chk(32'(cyc - t0), 32'h8c);
    t0 = cyc;
    wr(ocpw_pkg::OFF_CH_VAL, 32'h64);
    wait_chg(0, 3000);
    chk(32'(cyc - t0), 32'h96);
    rst;
    wr(adr(ocpw_pkg::OFF_CH_CTL, 1), 32'h12);
    cfg(0, 6'h32, 16'h0032, 16'h00ff);
    meas(0);
    chk(32'(hi), 32'h32);
    chk({30'h0, pin_lvl[1], chan_oe[1]}, 32'h2);
    wait_chg(0, 3000);
    wr(adr(ocpw_pkg::OFF_CH_VAL, 1), 32'h64);
    rd(ocpw_pkg::OFF_STAT, v);
    chk((v >> 9) & 32'h1, 32'h0);
    meas(0);
    chk(32'(hi), 32'h64);
    rd(ocpw_pkg::OFF_STAT, v);
    chk(v & 32'h201, 32'h201);
    // counter advances twice before the freeze and once after it, 40 frozen edges between
    rd(ocpw_pkg::OFF_CNT, v);
    ce <= 1'b0;
    repeat (40) @(posedge aclk);
    ce <= 1'b1;
    rd(ocpw_pkg::OFF_CNT, w);
    chk(w, (v + 32'h3) & 32'hff);
    give_verdict;
  end
endmodule : ocpw_top_test
